// ===== src/tpbd_pkg.sv
/*
 * Package for the texel palette and block decoder: formats, field
 * positions, block modes, channel constants and the carrier structs.
 * Assumes nothing of its surroundings.
 */
package tpbd_pkg;

    // Texel format codes presented by the sampler
    typedef enum logic [3:0] {
        FMT_NIBBLE_INDEX_LOW_ALPHA_HIGH = 4'h0,
        FMT_NIBBLE_INDEX_HIGH_ALPHA_LOW = 4'h1,
        FMT_BYTE_INDEX_LOW_ALPHA_HIGH   = 4'h2,
        FMT_BYTE_INDEX_HIGH_ALPHA_LOW   = 4'h3,
        FMT_BYTE_INDEX_ONLY             = 4'h4,
        FMT_TWO_BIT_INDEX_ONLY          = 4'h5,
        FMT_COMPRESSED_BLOCK            = 4'h6
    } tpbd_fmt_t;

    // Compressed block mode, one-hot
    typedef enum logic [3:0] {
        MODE_HIGH_PRECISION = 4'h1,
        MODE_FOUR_COLOUR    = 4'h2,
        MODE_ALPHA_COLOUR   = 4'h4,
        MODE_SPLIT_TABLE    = 4'h8
    } tpbd_mode_t;

    localparam int BLK_W        = 128;
    localparam int MODE_HI_BIT  = 127;
    localparam int MODE_MID_BIT = 126;
    localparam int MODE_LO_BIT  = 125;

    // High-precision mode layout
    localparam int HP_C1_TOP    = 125;
    localparam int HP_C0_TOP    = 110;
    localparam int HP_SEL_W     = 3;
    localparam logic [2:0] HP_SEL_TRANSPARENT = 3'h7;
    localparam logic [2:0] HP_SEL_C1          = 3'h6;
    localparam logic [7:0] HP_DIVISOR         = 8'h06;
    localparam logic [7:0] HP_ROUND           = 8'h03;

    // Four-colour direct mode layout
    localparam int FC_C3_TOP    = 123;
    localparam int FC_COLOUR_W  = 15;
    localparam int FC_SEL_W     = 2;

    localparam logic [7:0] ALPHA_OPAQUE = 8'hFF;
    localparam logic [7:0] ALPHA_CLEAR  = 8'h00;

    // Pipeline depth from request to result
    localparam int LATENCY      = 2;

    typedef struct packed {
        logic [7:0] a;
        logic [7:0] r;
        logic [7:0] g;
        logic [7:0] b;
    } tpbd_argb_t;

    typedef struct packed {
        logic [7:0] r;
        logic [7:0] g;
        logic [7:0] b;
    } tpbd_rgb_t;

    typedef struct packed {
        logic [127:0] word;
        tpbd_fmt_t    fmt;
        logic [4:0]   texel;
    } tpbd_req_t;

endpackage

// ===== src/tpbd_lerp6.sv
/*
 * Sixths interpolator for one colour channel of the high-precision mode.
 * Assumes k lies in 1..5; purely combinational.
 */
`timescale 1ns/1ps
`default_nettype none

module tpbd_lerp6 (
    input  wire logic [7:0] c0,
    input  wire logic [7:0] c1,
    input  wire logic [2:0] k,
    output logic      [7:0] y
);
    logic [11:0] sum;
    logic [11:0] w0;
    logic [11:0] w1;

    // Worst case 6*255+3 fits in 11 bits
    assign w0  = 12'(tpbd_pkg::HP_SEL_C1 - k);
    assign w1  = 12'(k);
    assign sum = w0 * 12'(c0) + w1 * 12'(c1) + 12'(tpbd_pkg::HP_ROUND);
    assign y   = 8'(sum / 12'(tpbd_pkg::HP_DIVISOR));

endmodule

`default_nettype wire

// ===== src/tpbd_decoder.sv
/*
 * Texel palette and block decoder. Unpacks paletted texel formats into
 * a palette index and alpha, looks the index up in the external
 * palette, and decodes high-precision and four-colour 128-bit blocks into ARGB texels, flagging the other two modes.
 * Assumes the palette store answers a read in exactly one cycle and
 * that the sampler holds no expectation of back-pressure.
 */
// Operation
// - High-alpha nibble format: alpha high, index low
// - Four-bit alpha copied into both nibbles
// - Nibble index selects 24-bit palette RGB
// - Low-alpha nibble format: index high, alpha low
// - High-alpha byte format: alpha high byte
// - Low-alpha byte format: index high byte
// - Byte index selects 24-bit RGB, alpha own
// - Byte-only index selects full ARGB entry
// - Two-bit index selects full ARGB entry
// - Block holds two 4x4 tiles, row-major
// - Top three bits choose the block mode
// - High-precision: two 5:5:5 base colours extracted
// - High-precision: 3-bit selectors packed from bit 0
// - Five-bit channel widened by repeating top bits
// - Entries 0,6 bases; 1..5 rounded sixths
// - Selector 7 gives transparent black
// - Four-colour mode: colours 3..0 from bit 123
// - Four-colour mode: 2-bit selectors in low half
// - Four-colour selector picks colour, alpha opaque
// - Result is ARGB, alpha in top byte
`timescale 1ns/1ps
`default_nettype none

module tpbd_decoder (
    input  wire logic                 clk_sys,
    input  wire logic                 rst_n,
    input  wire logic                 req_valid,
    input  wire tpbd_pkg::tpbd_req_t  req,
    output logic                      pal_rd,
    output logic [7:0]                pal_index,
    input  wire logic [31:0]          pal_data,
    output logic                      res_valid,
    output tpbd_pkg::tpbd_argb_t      res_argb,
    output logic                      res_elsewhere,
    output logic [127:0]              res_block,
    output logic [4:0]                res_texel
);

    ////////////////////////////////////////////////////////////////////
    // Helpers

    // Widen 5-bit channel to 8 bits
    function automatic logic [7:0] widen5(input logic [4:0] v);
        return {v, v[4:2]};
    endfunction

    function automatic tpbd_pkg::tpbd_rgb_t rgb555(input logic [14:0] v);
        tpbd_pkg::tpbd_rgb_t c;
        c.r = widen5(v[14:10]);
        c.g = widen5(v[9:5]);
        c.b = widen5(v[4:0]);
        return c;
    endfunction

    function automatic tpbd_pkg::tpbd_mode_t block_mode(input logic [127:0] w);
        tpbd_pkg::tpbd_mode_t m;
        if (w[tpbd_pkg::MODE_HI_BIT]) begin
            m = tpbd_pkg::MODE_SPLIT_TABLE;
        end else if (!w[tpbd_pkg::MODE_MID_BIT]) begin
            m = tpbd_pkg::MODE_HIGH_PRECISION;
        end else if (!w[tpbd_pkg::MODE_LO_BIT]) begin
            m = tpbd_pkg::MODE_FOUR_COLOUR;
        end else begin
            m = tpbd_pkg::MODE_ALPHA_COLOUR;
        end
        return m;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Stage 1: field extraction and palette request

    tpbd_pkg::tpbd_mode_t mode;
    tpbd_pkg::tpbd_rgb_t  hp_c0;
    tpbd_pkg::tpbd_rgb_t  hp_c1;
    tpbd_pkg::tpbd_rgb_t  fc_col [4];
    logic [2:0]           hp_sel;
    logic [1:0]           fc_sel;
    logic [7:0]           idx_d;
    logic [7:0]           alpha_d;
    logic                 use_pal_d;
    logic                 full_argb_d;
    logic                 elsewhere_d;
    tpbd_pkg::tpbd_argb_t blk_argb_d;
    tpbd_pkg::tpbd_rgb_t  hp_mix;
    // One net per channel: a packed struct may not take three drivers
    logic [7:0]           mix_r;
    logic [7:0]           mix_g;
    logic [7:0]           mix_b;

    assign mode  = block_mode(req.word);
    assign hp_c1 = rgb555(req.word[tpbd_pkg::HP_C1_TOP -: 15]);
    assign hp_c0 = rgb555(req.word[tpbd_pkg::HP_C0_TOP -: 15]);
    // Texel n selector at bits 3n+2:3n, texel 31 at 95:93
    assign hp_sel = req.word[req.texel * tpbd_pkg::HP_SEL_W +: 3];
    // Texel n selector at 2n+1:2n, texel 31 at 63:62
    assign fc_sel = req.word[req.texel * tpbd_pkg::FC_SEL_W +: 2];

    // Colour 3 at top, colour 0 ending at bit 64; bit 124 ignored
    for (genvar i = 0; i < 4; i++) begin : g_fc
        assign fc_col[i] = rgb555(req.word[tpbd_pkg::FC_C3_TOP
                                  - (3 - i) * tpbd_pkg::FC_COLOUR_W -: 15]);
    end

    // Texel number already encodes tile and row-major position; the
    // selector address needs nothing further.

    tpbd_lerp6 u_interpolate_select_r (
        .c0 (hp_c0.r),
        .c1 (hp_c1.r),
        .k  (hp_sel),
        .y  (mix_r)
    );
    tpbd_lerp6 u_interpolate_select_g (
        .c0 (hp_c0.g),
        .c1 (hp_c1.g),
        .k  (hp_sel),
        .y  (mix_g)
    );
    tpbd_lerp6 u_interpolate_select_b (
        .c0 (hp_c0.b),
        .c1 (hp_c1.b),
        .k  (hp_sel),
        .y  (mix_b)
    );

    // Interpolated entry; only used for selectors 1..5
    assign hp_mix = {mix_r, mix_g, mix_b};

    always_comb begin
        idx_d       = 8'h00;
        alpha_d     = tpbd_pkg::ALPHA_OPAQUE;
        use_pal_d   = 1'b0;
        full_argb_d = 1'b0;
        elsewhere_d = 1'b0;
        blk_argb_d  = '0;
        case (req.fmt)
            tpbd_pkg::FMT_NIBBLE_INDEX_LOW_ALPHA_HIGH: begin
                alpha_d   = {req.word[7:4], req.word[7:4]};
                idx_d     = {4'h0, req.word[3:0]};
                use_pal_d = 1'b1;
            end
            tpbd_pkg::FMT_NIBBLE_INDEX_HIGH_ALPHA_LOW: begin
                alpha_d   = {req.word[3:0], req.word[3:0]};
                idx_d     = {4'h0, req.word[7:4]};
                use_pal_d = 1'b1;
            end
            tpbd_pkg::FMT_BYTE_INDEX_LOW_ALPHA_HIGH: begin
                alpha_d   = req.word[15:8];
                idx_d     = req.word[7:0];
                use_pal_d = 1'b1;
            end
            tpbd_pkg::FMT_BYTE_INDEX_HIGH_ALPHA_LOW: begin
                alpha_d   = req.word[7:0];
                idx_d     = req.word[15:8];
                use_pal_d = 1'b1;
            end
            tpbd_pkg::FMT_BYTE_INDEX_ONLY: begin
                idx_d       = req.word[7:0];
                use_pal_d   = 1'b1;
                full_argb_d = 1'b1;
            end
            tpbd_pkg::FMT_TWO_BIT_INDEX_ONLY: begin
                idx_d       = {6'h00, req.word[1:0]};
                use_pal_d   = 1'b1;
                full_argb_d = 1'b1;
            end
            tpbd_pkg::FMT_COMPRESSED_BLOCK: begin
                case (mode)
                    tpbd_pkg::MODE_HIGH_PRECISION: begin
                        if (hp_sel == tpbd_pkg::HP_SEL_TRANSPARENT) begin
                            blk_argb_d = '0;
                        end else if (hp_sel == 3'h0) begin
                            blk_argb_d = {tpbd_pkg::ALPHA_OPAQUE, hp_c0};
                        end else if (hp_sel == tpbd_pkg::HP_SEL_C1) begin
                            blk_argb_d = {tpbd_pkg::ALPHA_OPAQUE, hp_c1};
                        end else begin
                            blk_argb_d = {tpbd_pkg::ALPHA_OPAQUE, hp_mix};
                        end
                    end
                    tpbd_pkg::MODE_FOUR_COLOUR: begin
                        blk_argb_d = {tpbd_pkg::ALPHA_OPAQUE, fc_col[fc_sel]};
                    end
                    tpbd_pkg::MODE_ALPHA_COLOUR, tpbd_pkg::MODE_SPLIT_TABLE: begin
                        elsewhere_d = 1'b1;
                    end
                    default: begin
                        elsewhere_d = 1'b1;
                    end
                endcase
            end
            default: begin
                blk_argb_d = '0;
            end
        endcase
    end

    // Palette read goes out combinationally so its answer lines up
    assign pal_rd    = req_valid & use_pal_d;
    assign pal_index = idx_d;

    ////////////////////////////////////////////////////////////////////
    // Stage 1 registers

    logic                 s1_valid_q;
    logic                 s1_use_pal_q;
    logic                 s1_full_q;
    logic                 s1_else_q;
    logic [7:0]           s1_alpha_q;
    tpbd_pkg::tpbd_argb_t s1_argb_q;
    logic [127:0]         s1_block_q;
    logic [4:0]           s1_texel_q;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s1_valid_q <= 1'b0;
        end else begin
            s1_valid_q <= req_valid;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s1_use_pal_q <= 1'b0;
            s1_full_q    <= 1'b0;
            s1_else_q    <= 1'b0;
            s1_alpha_q   <= 8'h00;
            s1_argb_q    <= '0;
            s1_block_q   <= '0;
            s1_texel_q   <= 5'h00;
        end else if (req_valid) begin
            s1_use_pal_q <= use_pal_d;
            s1_full_q    <= full_argb_d;
            s1_else_q    <= elsewhere_d;
            s1_alpha_q   <= alpha_d;
            s1_argb_q    <= blk_argb_d;
            s1_block_q   <= req.word;
            s1_texel_q   <= req.texel;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Stage 2: merge palette answer, register result

    tpbd_pkg::tpbd_argb_t argb_d;

    always_comb begin
        argb_d = s1_argb_q;
        if (s1_use_pal_q) begin
            if (s1_full_q) begin
                argb_d = pal_data;
            end else begin
                // Palette RGB, alpha from the texel itself
                argb_d = {s1_alpha_q, pal_data[23:0]};
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            res_valid <= 1'b0;
        end else begin
            res_valid <= s1_valid_q;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            res_argb      <= '0;
            res_elsewhere <= 1'b0;
            res_block     <= '0;
            res_texel     <= 5'h00;
        end else if (s1_valid_q) begin
            res_argb      <= s1_else_q ? '0 : argb_d;
            res_elsewhere <= s1_else_q;
            // Block forwarded untouched for the other decoder
            res_block     <= s1_block_q;
            res_texel     <= s1_texel_q;
        end
    end

endmodule

`default_nettype wire

// ===== verif/tpbd_decoder_asserts.sv
/*
 * Port checker for the texel palette and block decoder.
 * Assumes it is bound onto tpbd_decoder with one clock and one reset.
 */
`timescale 1ns/1ps
`default_nettype none

module tpbd_decoder_asserts (
    input wire logic                 clk_sys,
    input wire logic                 rst_n,
    input wire logic                 req_valid,
    input wire tpbd_pkg::tpbd_req_t  req,
    input wire logic                 pal_rd,
    input wire logic [7:0]           pal_index,
    input wire logic [31:0]          pal_data,
    input wire logic                 res_valid,
    input wire tpbd_pkg::tpbd_argb_t res_argb,
    input wire logic                 res_elsewhere,
    input wire logic [127:0]         res_block,
    input wire logic [4:0]           res_texel
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    logic [127:0] blk;
    logic [7:0]   low_byte;
    logic         take;
    assign blk      = req.word;
    assign low_byte = req.word[7:0];
    assign take     = req_valid && req.fmt == 4'h6;

    ////////////////////////////////////////////////////////////////////////////
    lat_two_a: assert property (req_valid |-> ##2 res_valid)
        else $error("result missing two cycles after request");
    no_orphan_a: assert property (res_valid |-> $past(req_valid, 2))
        else $error("result without request");
    nib_hi_a: assert property (req_valid && req.fmt == 4'h0 |->
        pal_rd && pal_index[3:0] == req.word[3:0]) else $error("nibble index low wrong");
    nib_lo_a: assert property (req_valid && req.fmt == 4'h1 |->
        pal_rd && pal_index[3:0] == req.word[7:4]) else $error("nibble index high wrong");
    byte_lo_a: assert property (req_valid && req.fmt == 4'h2 |->
        pal_rd && pal_index == req.word[7:0]) else $error("byte index low wrong");
    byte_hi_a: assert property (req_valid && req.fmt == 4'h3 |->
        pal_rd && pal_index == req.word[15:8]) else $error("byte index high wrong");
    byte_only_a: assert property (req_valid && req.fmt == 4'h4 |->
        pal_rd && pal_index == req.word[7:0]) else $error("byte-only index wrong");
    two_bit_a: assert property (req_valid && req.fmt == 4'h5 |->
        pal_rd && pal_index[1:0] == req.word[1:0]) else $error("two-bit index wrong");
    alpha_wide_a: assert property (req_valid && req.fmt < 4'h2 |->
        ##2 res_argb.a[7:4] == res_argb.a[3:0]) else $error("nibble alpha not copied");
    alpha_byte_a: assert property (req_valid && req.fmt == 4'h3 |->
        ##2 res_argb.a == $past(low_byte, 2)) else $error("byte alpha wrong");
    elsewhere_a: assert property (take && (req.word[127] || req.word[126:125] == 2'b11) |->
        ##2 res_elsewhere && res_argb == 32'h0) else $error("handed-off block not flagged");
    fwd_block_a: assert property (req_valid |-> ##2 res_block == $past(blk, 2))
        else $error("block not forwarded");
    chroma_opaque_a: assert property (take && req.word[127:125] == 3'b010 |->
        ##2 res_argb.a == 8'hFF && !res_elsewhere) else $error("four-colour alpha wrong");
endmodule

bind tpbd_decoder tpbd_decoder_asserts u_asserts (.clk_sys, .rst_n, .req_valid, .req, .pal_rd,
    .pal_index, .pal_data, .res_valid, .res_argb, .res_elsewhere, .res_block, .res_texel);

`default_nettype wire

// ===== verif/tpbd_palette_model.sv
/*
 * Behavioural texture palette store facing the decoder.
 * Assumes the decoder wants the entry one cycle after its read strobe.
 */
`timescale 1ns/1ps
`default_nettype none

module tpbd_palette_model (
    input  wire logic        clk_sys,
    input  wire logic        pal_rd,
    input  wire logic [7:0]  pal_index,
    output var  logic [31:0] pal_data = 32'h0
);
    // Top byte nonzero except at index 5A, so a leak into 24-bit formats shows
    always_ff @(posedge clk_sys) begin
        if (pal_rd) begin
            pal_data <= {pal_index ^ 8'h5A, ~pal_index, pal_index, pal_index ^ 8'hC3};
        end else begin
            pal_data <= ~pal_data; // Stale data must not look valid
        end
    end
endmodule

`default_nettype wire

// ===== verif/tpbd_decoder_bench.sv
/*
 * Self-checking bench for the texel palette and block decoder.
 * Assumes the palette model and the bound port checker.
 */
`timescale 1ns/1ps
`default_nettype none

module tpbd_decoder_bench;
    typedef struct packed {
        logic [127:0] blk;
        logic [4:0]   tx;
        logic [31:0]  argb;
        logic         els;
    } tpbd_exp_t;

    logic                 clk_sys   = 1'b0;
    logic                 rst_n     = 1'b0;
    logic                 req_valid = 1'b0;
    tpbd_pkg::tpbd_req_t  req       = '0;
    logic                 pal_rd;
    logic [7:0]           pal_index;
    logic [31:0]          pal_data;
    logic                 res_valid;
    tpbd_pkg::tpbd_argb_t res_argb;
    logic                 res_elsewhere;
    logic [127:0]         res_block;
    logic [4:0]           res_texel;
    int                   n_errors    = 0;
    int                   checks_done = 0;
    tpbd_exp_t            exp_q[$];
    tpbd_exp_t            cur;

    tpbd_decoder uut (.clk_sys, .rst_n, .req_valid, .req, .pal_rd, .pal_index, .pal_data,
        .res_valid, .res_argb, .res_elsewhere, .res_block, .res_texel);
    tpbd_palette_model u_pal (.clk_sys, .pal_rd, .pal_index, .pal_data);

    initial forever #25 clk_sys = ~clk_sys;

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] pal_ent(input logic [7:0] i);
        return {i ^ 8'h5A, ~i, i, i ^ 8'hC3};
    endfunction

    function automatic logic [31:0] with_a(input logic [7:0] a, input logic [7:0] i);
        logic [31:0] p;
        p = pal_ent(i);
        return {a, p[23:0]};
    endfunction

    function automatic logic [7:0] x5(input logic [4:0] v);
        return {v, v[4:2]};
    endfunction

    function automatic logic [7:0] mix(input int p, input int q, input int k);
        int v;
        v = ((6 - k) * p + k * q + 3) / 6;
        return v[7:0];
    endfunction

    task automatic end_of_test;
        $display("Checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Held high between sends, so back-to-back requests never glitch
    task automatic send(input logic [127:0] w, input logic [3:0] f, input logic [4:0] t,
                        input logic [31:0] a, input logic e);
        @(posedge clk_sys);
        req_valid <= 1'b1;
        req       <= {w, f, t};
        exp_q.push_back({w, t, a, e});
    endtask

    task automatic drain;
        @(posedge clk_sys);
        req_valid <= 1'b0;
        for (int i = 0; i < 20 && exp_q.size() > 0; i++) @(posedge clk_sys);
        if (exp_q.size() > 0) begin
            n_errors++;
            $display("Error pending results expected 0 seen %0d", exp_q.size());
            end_of_test();
        end
    endtask

    always @(posedge clk_sys) begin
        #1;
        if (res_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                n_errors++;
                $display("Error res_valid expected 0 seen 1");
            end else begin
                cur = exp_q.pop_front();
                chk("res_argb", cur.argb, res_argb);
                chk("res_elsewhere", cur.els, res_elsewhere);
                chk("res_block", cur.blk, res_block);
                chk("res_texel", cur.tx, res_texel);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_palette;
        logic [127:0] w;
        w = {{7{16'hA55A}}, 16'hC3E7};
        send(w, 4'h0, 5'h00, with_a(8'hEE, 8'h07), 1'b0);
        send(w, 4'h1, 5'h01, with_a(8'h77, 8'h0E), 1'b0);
        send(w, 4'h2, 5'h02, with_a(8'hC3, 8'hE7), 1'b0);
        send(w, 4'h3, 5'h03, with_a(8'hE7, 8'hC3), 1'b0);
        send(w, 4'h4, 5'h04, pal_ent(8'hE7), 1'b0);
        send(w, 4'h5, 5'h05, pal_ent(8'h03), 1'b0);
        send(w, 4'h7, 5'h06, 32'h0, 1'b0);
        drain();
    endtask

    task automatic t_high_prec;
        logic [127:0] b;
        logic [23:0]  c0;
        logic [23:0]  c1;
        logic [2:0]   s;
        b = '0;
        b[125:96] = {15'h4D2B, 15'h19C6}; // Red of colour 1 sets bit 125
        for (int n = 0; n < 32; n++) b[3*n +: 3] = 3'(n + n / 8);
        c1 = {x5(b[125:121]), x5(b[120:116]), x5(b[115:111])};
        c0 = {x5(b[110:106]), x5(b[105:101]), x5(b[100:96])};
        for (int n = 0; n < 32; n++) begin
            s = b[3*n +: 3];
            send(b, 4'h6, 5'(n), (s == 3'h7) ? 32'h0 : {8'hFF, mix(c0[23:16], c1[23:16], s),
                mix(c0[15:8], c1[15:8], s), mix(c0[7:0], c1[7:0], s)}, 1'b0);
        end
        drain();
    endtask

    task automatic t_four_colour;
        logic [127:0] b;
        logic [14:0]  c;
        b = '0;
        b[127:124] = 4'b0101; // Unused bit set, must not change anything
        b[123:64] = 60'h9C3A75E1B40DF62;
        for (int n = 0; n < 32; n++) b[2*n +: 2] = 2'(n ^ (n >> 2));
        for (int n = 0; n < 32; n++) begin
            c = b[64 + 15 * b[2*n +: 2] +: 15];
            send(b, 4'h6, 5'(n), {8'hFF, x5(c[14:10]), x5(c[9:5]), x5(c[4:0])}, 1'b0);
        end
        drain();
    endtask

    task automatic t_elsewhere;
        send({3'b011, 125'h1F0E2D3C4B5A69788796A5B4C3D2E1}, 4'h6, 5'h1F, 32'h0, 1'b1);
        send({3'b100, 125'h0123456789ABCDEF0123456789ABCD}, 4'h6, 5'h10, 32'h0, 1'b1);
        send({3'b111, 125'h1FEDCBA9876543210FEDCBA9876543}, 4'h6, 5'h00, 32'h0, 1'b1);
        drain();
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_palette();
        t_high_prec();
        t_four_colour();
        t_elsewhere();
        end_of_test();
    end
endmodule

`default_nettype wire
